// *** verilog/lpm_pkg.sv ***
// Constants for the per-channel line performance monitor counters.
// Assumes the channel select of the 8-bit processor bus is decoded outside,
// so only the low address byte of one framer reaches this block.
package lpm_pkg;

  // Register offsets within one framer's address page.
  localparam logic [7:0] GLOBAL_UPDATE_ADDR = 8'h0D;
  localparam logic [7:0] STATUS_ADDR = 8'h58;
  localparam logic [7:0] FRAMING_ADDR = 8'h59;
  localparam logic [7:0] EVT_LO_ADDR = 8'h5A;
  localparam logic [7:0] EVT_HI_ADDR = 8'h5B;
  localparam logic [7:0] BIT_LO_ADDR = 8'h5C;
  localparam logic [7:0] BIT_HI_ADDR = 8'h5D;
  localparam logic [7:0] CV_LO_ADDR = 8'h5E;
  localparam logic [7:0] CV_HI_ADDR = 8'h5F;

  // Field positions in the transfer status register.
  localparam int IRQ_ENABLE_BIT = 2;
  localparam int TRANSFER_DONE_BIT = 1;
  localparam int HOLDING_OVERRUN_BIT = 0;

  // Values after reset.
  localparam logic RST_IRQ_ENABLE = 1'b0;
  localparam logic RST_TRANSFER_DONE = 1'b0;
  localparam logic RST_OVERRUN = 1'b0;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // Timing: clock period, latch completion limit and host wait.
  localparam int CLK_PERIOD_NS = 10;
  localparam int LATCH_LIMIT_TENTHS = 35;
  localparam int LATCH_MAX_CYCLES = LATCH_LIMIT_TENTHS / 10;
  localparam int HOST_WAIT_NS = 2300;
  localparam int HOST_WAIT_CYCLES = (HOST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of one cycle's event increment into any counter.
  localparam int INC_W = 4;

endpackage : lpm_pkg

// *** verilog/lpm_event_counter.sv ***
// Saturating event counter with a restart that loads the current increment.
// Assumes the increment is already gated by the caller for mode and alignment.
`timescale 1ns/1ns
module lpm_event_counter
  import lpm_pkg::*;
#(
  parameter int W = 10
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic restart_i,
  input wire logic [INC_W-1:0] inc_i,
  output logic [W-1:0] count_o
);

  typedef struct packed {
    logic [W-1:0] count;
  } lpm_cnt_state_t;

  lpm_cnt_state_t st;
  lpm_cnt_state_t next_st;
  logic [W:0] sum;

  // Restart keeps this cycle's events, otherwise add and stop at the top.
  always_comb begin
    next_st = st;
    sum = {1'b0, st.count} + (W+1)'(inc_i);
    if (restart_i) begin
      next_st.count = W'(inc_i);
    end else if (sum[W]) begin
      next_st.count = '1;
    end else begin
      next_st.count = sum[W-1:0];
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_o = st.count;

endmodule : lpm_event_counter

// *** verilog/lpm_monitor.sv ***
// Per-channel performance monitor: four event counters, their holding
// registers, the transfer status register and the interrupt output.
// Assumes one clock at line rate, synchronous inputs, and that the framer
// delivers one-cycle event pulses and alignment levels for this channel.
`timescale 1ns/1ns
module lpm_monitor
  import lpm_pkg::*;
#(
  parameter int FRM_W = 7,
  parameter int EVT_W = 10,
  parameter int BIT_W = 10,
  parameter int CV_W = 13
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic irq_out_n_o,
  input wire logic e1_mode_select_i,
  input wire logic count_alignment_change_sel_i,
  input wire logic excess_zero_exclude_i,
  input wire logic fas_word_count_sel_i,
  input wire logic nfas_bit2_count_en_i,
  input wire logic in_frame_flag_i,
  input wire logic out_of_frame_i,
  input wire logic out_of_multiframe_i,
  input wire logic t1_framing_bit_err_i,
  input wire logic [2:0] fas_bit_errs_i,
  input wire logic fas_word_err_i,
  input wire logic nfas_bit2_zero_i,
  input wire logic reframe_i,
  input wire logic alignment_change_i,
  input wire logic far_block_err_i,
  input wire logic [2:0] t1_bit_errs_i,
  input wire logic crc_err_i,
  input wire logic bipolar_viol_i,
  input wire logic excess_zero_i
);

  typedef struct packed {
    logic irq_en;
    logic done;
    logic overrun;
    logic irq_n;
    logic [7:0] rdata;
    logic [FRM_W-1:0] hold_frm;
    logic [EVT_W-1:0] hold_evt;
    logic [BIT_W-1:0] hold_bit;
    logic [CV_W-1:0] hold_cv;
  } lpm_state_t;

  lpm_state_t st;
  lpm_state_t next_st;

  logic count_hit;
  logic latch;
  logic status_rd;
  logic e1;
  logic t1_ok;
  logic [INC_W-1:0] frm_inc;
  logic [INC_W-1:0] evt_inc;
  logic [INC_W-1:0] bit_inc;
  logic [INC_W-1:0] cv_inc;
  logic [FRM_W-1:0] frm_cnt;
  logic [EVT_W-1:0] evt_cnt;
  logic [BIT_W-1:0] bit_cnt;
  logic [CV_W-1:0] cv_cnt;

  // Latch request decode: any count location or the global update.
  assign count_hit = (addr_i >= FRAMING_ADDR) && (addr_i <= CV_HI_ADDR);
  assign latch = wr_i && (count_hit || addr_i == GLOBAL_UPDATE_ADDR);
  assign status_rd = rd_i && addr_i == STATUS_ADDR;

  // Mode select; T1-only event inputs are ignored while in E1 mode.
  assign e1 = e1_mode_select_i;
  assign t1_ok = !e1_mode_select_i;

  // Per-cycle increments, gated by mode and, except the T1 event and bit counts, by alignment state.
  always_comb begin
    frm_inc = '0;
    evt_inc = '0;
    bit_inc = '0;
    if (e1) begin
      if (!out_of_frame_i) begin
        frm_inc = fas_word_count_sel_i ? INC_W'(fas_word_err_i) : INC_W'(fas_bit_errs_i);
        frm_inc = frm_inc + INC_W'(nfas_bit2_count_en_i && nfas_bit2_zero_i);
        evt_inc = INC_W'(far_block_err_i);
      end
      if (!out_of_multiframe_i) begin
        bit_inc = INC_W'(crc_err_i);
      end
    end else if (t1_ok) begin
      if (in_frame_flag_i) begin
        frm_inc = INC_W'(t1_framing_bit_err_i);
      end
      evt_inc = count_alignment_change_sel_i ? INC_W'(alignment_change_i) : INC_W'(reframe_i);
      bit_inc = INC_W'(t1_bit_errs_i);
    end
  end

  // Code violations: bipolar violations plus optional excessive zeros.
  assign cv_inc = INC_W'(bipolar_viol_i) + INC_W'(excess_zero_i && !excess_zero_exclude_i);

  // Live counters; the latch restarts them with this cycle's events.
  // Framing error counter, seven bits wide by default.
  lpm_event_counter #(.W(FRM_W)) u_frm (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(latch),
    .inc_i(frm_inc),
    .count_o(frm_cnt)
  );
  // Reframe, alignment change or far-end block error counter.
  lpm_event_counter #(.W(EVT_W)) u_evt (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(latch),
    .inc_i(evt_inc),
    .count_o(evt_cnt)
  );
  // Bit error or CRC error counter.
  lpm_event_counter #(.W(BIT_W)) u_bit (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(latch),
    .inc_i(bit_inc),
    .count_o(bit_cnt)
  );
  // Code violation counter, thirteen bits wide by default.
  lpm_event_counter #(.W(CV_W)) u_cv (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(latch),
    .inc_i(cv_inc),
    .count_o(cv_cnt)
  );

  // Holding registers, status flags, interrupt and read data.
  always_comb begin
    next_st = st;
    if (latch) begin
      next_st.hold_frm = frm_cnt;
      next_st.hold_evt = evt_cnt;
      next_st.hold_bit = bit_cnt;
      next_st.hold_cv = cv_cnt;
    end
    if (wr_i && addr_i == STATUS_ADDR) begin
      next_st.irq_en = wdata_i[IRQ_ENABLE_BIT];
    end
    // A latch in the same cycle as the status read wins over the clear.
    next_st.done = (st.done && !status_rd) || latch;
    next_st.overrun = (st.overrun && !status_rd) || (latch && st.done);
    next_st.irq_n = !(next_st.irq_en && next_st.done);
    if (rd_i) begin
      case (addr_i)
        STATUS_ADDR: begin
          next_st.rdata = 8'h00;
          next_st.rdata[IRQ_ENABLE_BIT] = st.irq_en;
          next_st.rdata[TRANSFER_DONE_BIT] = st.done;
          next_st.rdata[HOLDING_OVERRUN_BIT] = st.overrun;
        end
        FRAMING_ADDR: next_st.rdata = 8'(st.hold_frm);
        EVT_LO_ADDR: next_st.rdata = st.hold_evt[7:0];
        EVT_HI_ADDR: next_st.rdata = 8'(st.hold_evt[EVT_W-1:8]);
        BIT_LO_ADDR: next_st.rdata = st.hold_bit[7:0];
        BIT_HI_ADDR: next_st.rdata = 8'(st.hold_bit[BIT_W-1:8]);
        CV_LO_ADDR: next_st.rdata = st.hold_cv[7:0];
        CV_HI_ADDR: next_st.rdata = 8'(st.hold_cv[CV_W-1:8]);
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; holding values start at zero, software must latch first.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
      st.irq_en <= RST_IRQ_ENABLE;
      st.done <= RST_TRANSFER_DONE;
      st.overrun <= RST_OVERRUN;
      st.irq_n <= 1'b1;
      st.rdata <= RST_RDATA;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign irq_out_n_o = st.irq_n;

  // Checks on the transfer, status and counting behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // A latch always raises the transfer-done flag one cycle later.
  a_done_on_latch: assert property (latch |=> st.done)
    else $error("transfer-done not set after latch");

  // The code violation holding value is the live count at the latch edge.
  a_latch_in_time: assert property (latch |=> st.hold_cv == $past(cv_cnt))
    else $error("holding registers not loaded in time");

  // A status read without a latch clears both flags.
  a_status_clear: assert property (status_rd && !latch |=> !st.done && !st.overrun)
    else $error("status read did not clear flags");

  // A latch over an unread transfer flags the overrun.
  a_ovr_on_double: assert property (latch && st.done |=> st.overrun)
    else $error("overrun not flagged");

  // The overrun flag never rises without a latch over a pending transfer.
  a_ovr_needs_transfer_done: assert property (!st.overrun && !(latch && st.done) |=> !st.overrun)
    else $error("overrun set without cause");

  // An enabled transfer drives the interrupt output low.
  a_irq_enabled: assert property (latch && st.irq_en && !(wr_i && addr_i == STATUS_ADDR) |=> !irq_out_n_o)
    else $error("interrupt missing on transfer");

  // With the enable bit clear the interrupt output stays high.
  a_irq_disabled: assert property (!st.irq_en |-> irq_out_n_o)
    else $error("interrupt while disabled");

  // Holding values only move on a latch.
  a_hold_stable: assert property (!latch |=> $stable(st.hold_cv) && $stable(st.hold_evt))
    else $error("holding register changed without latch");

  // The latch captures the live counts of the same edge.
  a_hold_capture: assert property (latch |=> st.hold_frm == $past(frm_cnt) && st.hold_bit == $past(bit_cnt))
    else $error("holding capture wrong");

  // The restarted counter keeps the events of the latch cycle.
  a_count_restart: assert property (latch |=> cv_cnt == CV_W'($past(cv_inc)))
    else $error("counter did not restart with current events");

  // E1 framing count pauses while out of frame.
  a_fer_paused_e1: assert property (e1 && out_of_frame_i && !latch |=> $stable(frm_cnt))
    else $error("framing count moved while out of frame");

  // T1 framing count pauses while the in-frame flag is low.
  a_fer_paused_t1: assert property (!e1 && !in_frame_flag_i && !latch |=> $stable(frm_cnt))
    else $error("framing count moved while not in frame");

  // E1 CRC count pauses while out of multiframe alignment.
  a_crc_paused: assert property (e1 && out_of_multiframe_i && !latch |=> $stable(bit_cnt))
    else $error("crc count moved while out of multiframe");

  // In E1 mode only far-end block errors move the event counter.
  a_t1_held_off: assert property (e1 && !far_block_err_i && !latch |=> $stable(evt_cnt))
    else $error("t1 event counted in e1 mode");

  // A write to the global update location latches too.
  a_global_latch: assert property (wr_i && addr_i == GLOBAL_UPDATE_ADDR |=> st.done)
    else $error("global update did not latch");

  // A T1 reframe adds one when reframes are selected.
  a_t1_reframe: assert property (!e1 && !count_alignment_change_sel_i && reframe_i && !latch && evt_cnt != '1
    |=> evt_cnt == $past(evt_cnt) + EVT_W'(1))
    else $error("reframe not counted");

  // An E1 far-end block error adds one while in frame.
  a_far_block: assert property (e1 && !out_of_frame_i && far_block_err_i && !latch && evt_cnt != '1
    |=> evt_cnt == $past(evt_cnt) + EVT_W'(1))
    else $error("far-end block error not counted");

  // An E1 CRC error adds one while in multiframe alignment.
  a_crc_count: assert property (e1 && !out_of_multiframe_i && crc_err_i && !latch && bit_cnt != '1
    |=> bit_cnt == $past(bit_cnt) + BIT_W'(1))
    else $error("crc error not counted");

  // Excluded excess zeros alone leave the code violation count alone.
  a_cv_exclude: assert property (excess_zero_exclude_i && excess_zero_i && !bipolar_viol_i && !latch
    |=> $stable(cv_cnt))
    else $error("excluded excess zeros counted");

  // A status read returns the enable and both flags as they stood.
  a_status_data: assert property (status_rd |=> rdata_o == {5'h00, $past(st.irq_en), $past(st.done), $past(st.overrun)})
    else $error("status read data wrong");

  // Main scenarios: overrun, acknowledge, global update, interrupt, E1 counting.
  c_overrun: cover property (latch ##1 latch);
  c_status_read: cover property (st.done ##1 status_rd);
  c_global: cover property (wr_i && addr_i == GLOBAL_UPDATE_ADDR);
  c_irq: cover property (!irq_out_n_o);
  c_e1_count: cover property (e1 && far_block_err_i && crc_err_i);

endmodule : lpm_monitor

// *** verif/lpm_host.sv ***
// Processor bus model for the performance monitor: one-cycle read and write strobes.
// Assumes the caller runs the tasks from one process and the clock is free running.
`timescale 1ns/1ns
module lpm_host
  import lpm_pkg::*;
(
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  // Idle bus: strobes low, address and data parked away from the last value.
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  // One write; a single location per request keeps latches from doubling up.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~v;
  endtask : write_reg

  // One read; the data is taken in the cycle after the strobe edge.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    v = rdata_i;
  endtask : read_reg

  // Latch request, then the host wait before the counts are polled.
  task automatic latch(input logic [7:0] a);
    write_reg(a, 8'h00);
    repeat (HOST_WAIT_CYCLES) @(posedge clk_i);
  endtask : latch
endmodule : lpm_host

// *** verif/lpm_monitor_tb.sv ***
// Self-checking bench for the performance monitor in T1 and E1 modes.
// Assumes the host model drives the bus and this module drives framer events.
`timescale 1ns/1ns
module lpm_monitor_tb;
  import lpm_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic irq_n;
  logic mode = 1'b0;
  logic cac_sel = 1'b0;
  logic exz_excl = 1'b0;
  logic word_sel = 1'b0;
  logic nfas_en = 1'b0;
  logic in_frame = 1'b1;
  logic out_frame = 1'b0;
  logic oomf = 1'b0;
  logic [8:0] ev = 9'h000;
  logic [2:0] fb = 3'h0;
  logic [2:0] tb3 = 3'h0;
  logic [7:0] d;
  int num_errors = 0;
  int n_compared = 0;

  // Clock at the line-rate model period.
  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  lpm_monitor lpm_monitor_inst (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .rdata_o(rdata), .irq_out_n_o(irq_n), .e1_mode_select_i(mode),
    .count_alignment_change_sel_i(cac_sel), .excess_zero_exclude_i(exz_excl), .fas_word_count_sel_i(word_sel),
    .nfas_bit2_count_en_i(nfas_en), .in_frame_flag_i(in_frame), .out_of_frame_i(out_frame),
    .out_of_multiframe_i(oomf), .t1_framing_bit_err_i(ev[0]), .fas_bit_errs_i(fb), .fas_word_err_i(ev[1]),
    .nfas_bit2_zero_i(ev[2]), .reframe_i(ev[3]), .alignment_change_i(ev[4]), .far_block_err_i(ev[5]),
    .t1_bit_errs_i(tb3), .crc_err_i(ev[6]), .bipolar_viol_i(ev[7]), .excess_zero_i(ev[8]));

  lpm_host lpm_host_inst (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata));

  // Compares one byte and counts the result.
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Reads one register and compares it.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    lpm_host_inst.read_reg(a, d);
    cmp(d, exp);
  endtask : rd_chk

  // Reads the seven count bytes; byte 0 of the vector is the lowest location.
  task automatic counts_chk(input logic [55:0] exp);
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'(FRAMING_ADDR + i), exp[8*i+:8]);
    end
  endtask : counts_chk

  // Holds a set of event inputs high for n consecutive cycles.
  task automatic burst(input logic [8:0] m, input logic [2:0] f, input logic [2:0] t, input int n);
    @(posedge clk_i);
    #1;
    ev = m;
    fb = f;
    tb3 = t;
    repeat (n) @(posedge clk_i);
    #1;
    ev = 9'h000;
    fb = 3'h0;
    tb3 = 3'h0;
  endtask : burst

  // Waits a bounded span for the interrupt level, then compares it.
  task automatic irq_chk(input logic exp);
    for (int k = 0; k < LATCH_MAX_CYCLES && irq_n !== exp; k++) begin
      @(posedge clk_i);
      #1;
    end
    cmp({7'h00, irq_n}, {7'h00, exp});
  endtask : irq_chk

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    rd_chk(STATUS_ADDR, 8'h00);
    rd_chk(8'h40, RST_RDATA);
    // T1: framing, reframe, bit and code counts; the unselected event is ignored.
    burst(9'h199, 3'h5, 3'h3, 6);
    in_frame = 1'b0;
    burst(9'h001, 3'h0, 3'h0, 3);
    in_frame = 1'b1;
    cac_sel = 1'b1;
    burst(9'h018, 3'h0, 3'h0, 4);
    burst(9'h180, 3'h0, 3'h0, 150);
    lpm_host_inst.latch(CV_LO_ADDR);
    counts_chk(56'h01_38_00_12_00_0A_06);
    rd_chk(STATUS_ADDR, 8'h02);
    rd_chk(STATUS_ADDR, 8'h00);
    burst(9'h181, 3'h0, 3'h2, 5);
    counts_chk(56'h01_38_00_12_00_0A_06);
    // Interrupt on transfer, overrun on a second latch, restart of the counters.
    lpm_host_inst.write_reg(STATUS_ADDR, 8'h07);
    rd_chk(STATUS_ADDR, 8'h04);
    lpm_host_inst.write_reg(GLOBAL_UPDATE_ADDR, 8'h00);
    irq_chk(1'b0);
    lpm_host_inst.write_reg(EVT_HI_ADDR, 8'h00);
    rd_chk(STATUS_ADDR, 8'h07);
    irq_chk(1'b1);
    counts_chk(56'h0);
    lpm_host_inst.write_reg(STATUS_ADDR, 8'h00);
    lpm_host_inst.write_reg(8'h40, 8'h00);
    irq_chk(1'b1);
    rd_chk(STATUS_ADDR, 8'h00);
    lpm_host_inst.write_reg(FRAMING_ADDR, 8'h00);
    repeat (LATCH_MAX_CYCLES) @(posedge clk_i);
    #1;
    cmp({7'h00, irq_n}, 8'h01);
    rd_chk(STATUS_ADDR, 8'h02);
    // E1: alignment bits and words, far-end blocks, CRC, excess zeros left out.
    mode = 1'b1;
    nfas_en = 1'b1;
    exz_excl = 1'b1;
    burst(9'h1ED, 3'h3, 3'h7, 5);
    word_sel = 1'b1;
    burst(9'h002, 3'h3, 3'h0, 2);
    oomf = 1'b1;
    burst(9'h040, 3'h0, 3'h0, 3);
    out_frame = 1'b1;
    burst(9'h126, 3'h3, 3'h0, 3);
    lpm_host_inst.latch(CV_HI_ADDR);
    counts_chk(56'h00_05_00_05_00_05_16);
    rd_chk(STATUS_ADDR, 8'h02);
    final_report();
  end
endmodule : lpm_monitor_tb
